//--- hdl/pbr_regs.v
// pll control bus ports, reference receiver controls and power enable register bank on axi4-lite
// assumes: one clock, synchronous active low reset, pll bus signals on the same clock, shutdown pin asynchronous
// What this block does
// - write data byte stored, sent to pll bus
// - read-only readback byte from pll bus
// - two-bit field selects shutdown pin effect
// - bits 7,6 enable calibration blocks and clock
// - bits 2,1,0 enable bias, clock, front end
// - bit 5 switches on two extra channels
// - sixteen channel clock enables, reset zero
// - strobe bit pushes write byte onto bus
// - read enable bit loads readback from bus
`timescale 1ns/10ps
`include "pbr_consts.vh"

module pbr_regs #(
	parameter ADDR_W = 14
) (
	input wire core_clk_i,
	input wire nrst_i,
	input wire [ADDR_W-1:0] s_axi_awaddr_i,
	input wire s_axi_awvalid_i,
	output reg s_axi_awready_o,
	input wire [31:0] s_axi_wdata_i,
	input wire [3:0] s_axi_wstrb_i,
	input wire s_axi_wvalid_i,
	output reg s_axi_wready_o,
	output reg [1:0] s_axi_bresp_o,
	output reg s_axi_bvalid_o,
	input wire s_axi_bready_i,
	input wire [ADDR_W-1:0] s_axi_araddr_i,
	input wire s_axi_arvalid_i,
	output reg s_axi_arready_o,
	output reg [31:0] s_axi_rdata_o,
	output reg [1:0] s_axi_rresp_o,
	output reg s_axi_rvalid_o,
	input wire s_axi_rready_i,
	output reg [7:0] pll_bus_addr_o,
	output reg [7:0] pll_bus_wr_byte_o,
	output reg pll_bus_wr_strobe_o,
	output reg pll_bus_rd_en_o,
	input wire [7:0] pll_bus_rd_byte_i,
	input wire [7:0] pll_rev_i,
	output reg [3:0] ref_cm_ctrl_o,
	output reg ref_low_power_o,
	output reg ref_synca_sel_o,
	output reg ref_receiver_on_o,
	input wire shutdown_pin_i,
	output reg calib_analog_on_o,
	output reg calib_clock_on_o,
	output reg extra_chan_on_o,
	output reg converter_bias_on_o,
	output reg master_bias_on_o,
	output reg converter_clock_on_o,
	output reg front_end_on_o,
	output reg [15:0] chan_clock_on_o,
	output reg [5:0] gain_trim_o,
	output reg [5:0] cap_trim_o,
	output reg [7:0] dither_current_one_o,
	output reg [7:0] dither_current_two_o
);

	// software visible storage
	reg rd_en;
	reg wr_strobe;
	reg wr_strobe_prev;
	reg [7:0] bus_addr;
	reg [7:0] pll_bus_wr_byte;
	reg [7:0] pll_bus_rd_byte;
	reg [7:0] ref_ctrl;
	reg [7:0] pll_rev;
	reg [7:0] pwr_down;
	reg [7:0] chan_low;
	reg [7:0] chan_high;
	reg [7:0] gain_trim;
	reg [7:0] cap_trim;
	reg [7:0] dither_current_one;
	reg [7:0] dither_current_two;

	// write channel holding state
	reg aw_held;
	reg w_held;
	reg [`PBR_IDX_W-1:0] aw_idx;
	reg [7:0] w_byte;
	reg w_lane0;

	wire shutdown_level;
	wire do_write;
	reg [7:0] read_val;
	reg [1:0] pin_mode;
	reg gate_clock;
	reg gate_front_end;
	reg gate_master_bias;

	function is_mapped;
		input [`PBR_IDX_W-1:0] idx;
		begin
			case (idx)
				`PBR_IDX_RD_EN, `PBR_IDX_WR_STROBE, `PBR_IDX_BUS_ADDR, `PBR_IDX_WR_DATA,
				`PBR_IDX_RD_DATA, `PBR_IDX_REF_CTRL, `PBR_IDX_PLL_REV, `PBR_IDX_PWR_DOWN,
				`PBR_IDX_CHAN_LOW, `PBR_IDX_CHAN_HIGH, `PBR_IDX_GAIN_TRIM, `PBR_IDX_CAP_TRIM,
				`PBR_IDX_DITHER_ONE, `PBR_IDX_DITHER_TWO: is_mapped = 1'b1;
				default: is_mapped = 1'b0;
			endcase
		end
	endfunction

	// word index from a byte address; low two bits ignored
	function [`PBR_IDX_W-1:0] word_idx;
		input [ADDR_W-1:0] addr;
		begin
			word_idx = addr[`PBR_IDX_W+1:2];
		end
	endfunction

	pbr_pin_sync u_pin_sync (
		.core_clk_i(core_clk_i),
		.nrst_i(nrst_i),
		.pin_i(shutdown_pin_i),
		.level_o(shutdown_level)
	);

	assign do_write = aw_held && w_held && !s_axi_bvalid_o;

	// axi write address and data, taken in either order
	always @(posedge core_clk_i) begin
		if (!nrst_i) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_idx <= {`PBR_IDX_W{1'b0}};
			w_byte <= 8'h00;
			w_lane0 <= 1'b0;
			s_axi_awready_o <= 1'b1;
			s_axi_wready_o <= 1'b1;
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o <= `PBR_RESP_OKAY;
		end else begin
			if (s_axi_awvalid_i && s_axi_awready_o) begin
				aw_held <= 1'b1;
				aw_idx <= word_idx(s_axi_awaddr_i);
				s_axi_awready_o <= 1'b0;
			end
			if (s_axi_wvalid_i && s_axi_wready_o) begin
				w_held <= 1'b1;
				w_byte <= s_axi_wdata_i[7:0];
				w_lane0 <= s_axi_wstrb_i[0];
				s_axi_wready_o <= 1'b0;
			end
			if (do_write) begin
				s_axi_bvalid_o <= 1'b1;
				s_axi_bresp_o <= is_mapped(aw_idx) ? `PBR_RESP_OKAY : `PBR_RESP_SLVERR;
			end
			if (s_axi_bvalid_o && s_axi_bready_i) begin
				s_axi_bvalid_o <= 1'b0;
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_awready_o <= 1'b1;
				s_axi_wready_o <= 1'b1;
			end
		end
	end

	// register storage; writes masked to their fields so reserved bits stay zero
	always @(posedge core_clk_i) begin
		if (!nrst_i) begin
			rd_en <= 1'b0;
			wr_strobe <= 1'b0;
			wr_strobe_prev <= 1'b0;
			bus_addr <= `PBR_RST_ZERO;
			pll_bus_wr_byte <= `PBR_RST_ZERO;
			pll_bus_rd_byte <= `PBR_RST_ZERO;
			ref_ctrl <= `PBR_RST_REF_CTRL;
			pll_rev <= `PBR_RST_ZERO;
			pwr_down <= `PBR_RST_ZERO;
			chan_low <= `PBR_RST_ZERO;
			chan_high <= `PBR_RST_ZERO;
			gain_trim <= `PBR_RST_ZERO;
			cap_trim <= `PBR_RST_ZERO;
			dither_current_one <= `PBR_RST_ZERO;
			dither_current_two <= `PBR_RST_ZERO;
		end else begin
			wr_strobe_prev <= wr_strobe;
			pll_rev <= pll_rev_i;
			if (rd_en) begin
				pll_bus_rd_byte <= pll_bus_rd_byte_i;
			end
			if (do_write && w_lane0) begin
				case (aw_idx)
					`PBR_IDX_RD_EN: rd_en <= w_byte[0];
					`PBR_IDX_WR_STROBE: wr_strobe <= w_byte[0];
					`PBR_IDX_BUS_ADDR: bus_addr <= w_byte;
					`PBR_IDX_WR_DATA: pll_bus_wr_byte <= w_byte;
					`PBR_IDX_REF_CTRL: ref_ctrl <= w_byte & `PBR_MASK_REF_CTRL;
					`PBR_IDX_PWR_DOWN: pwr_down <= w_byte;
					`PBR_IDX_CHAN_LOW: chan_low <= w_byte;
					`PBR_IDX_CHAN_HIGH: chan_high <= w_byte;
					`PBR_IDX_GAIN_TRIM: gain_trim <= w_byte & `PBR_MASK_TRIM;
					`PBR_IDX_CAP_TRIM: cap_trim <= w_byte & `PBR_MASK_TRIM;
					`PBR_IDX_DITHER_ONE: dither_current_one <= w_byte;
					`PBR_IDX_DITHER_TWO: dither_current_two <= w_byte;
					default: ;
				endcase
			end
		end
	end

	// read mux; unmapped words read zero
	always @* begin
		read_val = 8'h00;
		case (word_idx(s_axi_araddr_i))
			`PBR_IDX_RD_EN: read_val = {7'h00, rd_en};
			`PBR_IDX_WR_STROBE: read_val = {7'h00, wr_strobe};
			`PBR_IDX_BUS_ADDR: read_val = bus_addr;
			`PBR_IDX_WR_DATA: read_val = pll_bus_wr_byte;
			`PBR_IDX_RD_DATA: read_val = pll_bus_rd_byte;
			`PBR_IDX_REF_CTRL: read_val = ref_ctrl;
			`PBR_IDX_PLL_REV: read_val = pll_rev;
			`PBR_IDX_PWR_DOWN: read_val = pwr_down;
			`PBR_IDX_CHAN_LOW: read_val = chan_low;
			`PBR_IDX_CHAN_HIGH: read_val = chan_high;
			`PBR_IDX_GAIN_TRIM: read_val = gain_trim;
			`PBR_IDX_CAP_TRIM: read_val = cap_trim;
			`PBR_IDX_DITHER_ONE: read_val = dither_current_one;
			`PBR_IDX_DITHER_TWO: read_val = dither_current_two;
			default: read_val = 8'h00;
		endcase
	end

	// axi read channel, one read under way at a time
	always @(posedge core_clk_i) begin
		if (!nrst_i) begin
			s_axi_arready_o <= 1'b1;
			s_axi_rvalid_o <= 1'b0;
			s_axi_rdata_o <= 32'h0000_0000;
			s_axi_rresp_o <= `PBR_RESP_OKAY;
		end else begin
			if (s_axi_arvalid_i && s_axi_arready_o) begin
				s_axi_arready_o <= 1'b0;
				s_axi_rvalid_o <= 1'b1;
				s_axi_rdata_o <= {24'h000000, read_val};
				s_axi_rresp_o <= is_mapped(word_idx(s_axi_araddr_i)) ? `PBR_RESP_OKAY : `PBR_RESP_SLVERR;
			end else if (s_axi_rvalid_o && s_axi_rready_i) begin
				s_axi_rvalid_o <= 1'b0;
				s_axi_arready_o <= 1'b1;
			end
		end
	end

	// shutdown pin gating by behaviour code
	always @* begin
		pin_mode = pwr_down[`PBR_PD_MODE_HI:`PBR_PD_MODE_LO];
		gate_clock = 1'b0;
		gate_front_end = 1'b0;
		gate_master_bias = 1'b0;
		if (shutdown_level) begin
			case (pin_mode)
				`PBR_PIN_IGNORE: gate_clock = 1'b0;
				`PBR_PIN_CLOCK_ONLY: gate_clock = 1'b1;
				`PBR_PIN_CLOCK_BIAS: begin
					gate_clock = 1'b1;
					gate_front_end = 1'b1;
				end
				`PBR_PIN_ALL: begin
					gate_clock = 1'b1;
					gate_front_end = 1'b1;
					gate_master_bias = 1'b1;
				end
				default: gate_clock = 1'b0;
			endcase
		end
	end

	// registered control outputs
	always @(posedge core_clk_i) begin
		if (!nrst_i) begin
			pll_bus_addr_o <= 8'h00;
			pll_bus_wr_byte_o <= 8'h00;
			pll_bus_wr_strobe_o <= 1'b0;
			pll_bus_rd_en_o <= 1'b0;
			ref_cm_ctrl_o <= 4'h0;
			ref_low_power_o <= 1'b0;
			ref_synca_sel_o <= 1'b0;
			ref_receiver_on_o <= 1'b1;
			calib_analog_on_o <= 1'b0;
			calib_clock_on_o <= 1'b0;
			extra_chan_on_o <= 1'b0;
			converter_bias_on_o <= 1'b0;
			master_bias_on_o <= 1'b0;
			converter_clock_on_o <= 1'b0;
			front_end_on_o <= 1'b0;
			chan_clock_on_o <= 16'h0000;
			gain_trim_o <= 6'h00;
			cap_trim_o <= 6'h00;
			dither_current_one_o <= 8'h00;
			dither_current_two_o <= 8'h00;
		end else begin
			pll_bus_addr_o <= bus_addr;
			pll_bus_wr_byte_o <= pll_bus_wr_byte;
			pll_bus_wr_strobe_o <= wr_strobe && !wr_strobe_prev;
			pll_bus_rd_en_o <= rd_en;
			ref_cm_ctrl_o <= ref_ctrl[`PBR_REF_CM_HI:`PBR_REF_CM_LO];
			ref_low_power_o <= ref_ctrl[`PBR_REF_LP_MODE];
			ref_synca_sel_o <= ref_ctrl[`PBR_REF_SYNCA];
			ref_receiver_on_o <= ref_ctrl[`PBR_REF_RX_ON];
			calib_analog_on_o <= pwr_down[`PBR_PD_CAL_ANA];
			calib_clock_on_o <= pwr_down[`PBR_PD_CAL_CLK];
			extra_chan_on_o <= pwr_down[`PBR_PD_EXTRA_CHAN];
			converter_bias_on_o <= pwr_down[`PBR_PD_BIAS];
			master_bias_on_o <= pwr_down[`PBR_PD_BIAS] && !gate_master_bias;
			converter_clock_on_o <= pwr_down[`PBR_PD_CONV_CLK] && !gate_clock;
			front_end_on_o <= pwr_down[`PBR_PD_FRONT_END] && !gate_front_end;
			chan_clock_on_o <= gate_clock ? 16'h0000 : {chan_high, chan_low};
			gain_trim_o <= gain_trim[5:0];
			cap_trim_o <= cap_trim[5:0];
			dither_current_one_o <= dither_current_one;
			dither_current_two_o <= dither_current_two;
		end
	end

endmodule // pbr_regs

//--- common/pbr_consts.vh
// register indices, field positions, reset values and synchroniser depth of the pll bus and power enable bank
// assumes: included by name from the design files; definitions only
`ifndef PBR_CONSTS_VH
`define PBR_CONSTS_VH

// register indices; byte address on the bus is four times the index
`define PBR_IDX_W 12
`define PBR_IDX_RD_EN 12'h50e
`define PBR_IDX_WR_STROBE 12'h50f
`define PBR_IDX_BUS_ADDR 12'h520
`define PBR_IDX_WR_DATA 12'h521
`define PBR_IDX_RD_DATA 12'h522
`define PBR_IDX_REF_CTRL 12'h523
`define PBR_IDX_PLL_REV 12'h524
`define PBR_IDX_PWR_DOWN 12'hb90
`define PBR_IDX_CHAN_LOW 12'hb91
`define PBR_IDX_CHAN_HIGH 12'hb92
`define PBR_IDX_GAIN_TRIM 12'hb94
`define PBR_IDX_CAP_TRIM 12'hb95
`define PBR_IDX_DITHER_ONE 12'hb99
`define PBR_IDX_DITHER_TWO 12'hb9a

// reset values
`define PBR_RST_ZERO 8'h00
`define PBR_RST_REF_CTRL 8'h01

// writable masks; zero bits are reserved and read as zero
`define PBR_MASK_ONE_BIT 8'h01
`define PBR_MASK_REF_CTRL 8'h7f
`define PBR_MASK_TRIM 8'h3f

// power down register fields
`define PBR_PD_CAL_ANA 7
`define PBR_PD_CAL_CLK 6
`define PBR_PD_EXTRA_CHAN 5
`define PBR_PD_MODE_HI 4
`define PBR_PD_MODE_LO 3
`define PBR_PD_BIAS 2
`define PBR_PD_CONV_CLK 1
`define PBR_PD_FRONT_END 0

// shutdown pin behaviour codes
`define PBR_PIN_IGNORE 2'b00
`define PBR_PIN_CLOCK_ONLY 2'b01
`define PBR_PIN_CLOCK_BIAS 2'b10
`define PBR_PIN_ALL 2'b11

// reference receiver control fields
`define PBR_REF_CM_HI 6
`define PBR_REF_CM_LO 3
`define PBR_REF_LP_MODE 2
`define PBR_REF_SYNCA 1
`define PBR_REF_RX_ON 0

// bus responses
`define PBR_RESP_OKAY 2'b00
`define PBR_RESP_SLVERR 2'b10

// pin synchroniser depth
`define PBR_SYNC_STAGES 3

`endif

//--- hdl/pbr_pin_sync.v
// three flop synchroniser with agreement filter for an asynchronous level
// assumes: the input comes from a pin outside the core clock domain
`timescale 1ns/10ps
`include "pbr_consts.vh"

module pbr_pin_sync (
	input wire core_clk_i,
	input wire nrst_i,
	input wire pin_i,
	output reg level_o
);

	reg stage_one;
	reg stage_two;
	reg stage_three;

	// stage_one feeds only stage_two; the filter looks at stages two and three
	always @(posedge core_clk_i) begin
		if (!nrst_i) begin
			stage_one <= 1'b0;
			stage_two <= 1'b0;
			stage_three <= 1'b0;
			level_o <= 1'b0;
		end else begin
			stage_one <= pin_i;
			stage_two <= stage_one;
			stage_three <= stage_two;
			if (stage_two == stage_three) begin
				level_o <= stage_three;
			end
		end
	end

endmodule // pbr_pin_sync

//--- dv/pbr_regs_checker.sv
// port-level assertions for the pll bus and power enable register bank
// assumes: bound into pbr_regs, ports matched by name
`timescale 1ns/10ps
module pbr_regs_checker (
	input wire core_clk_i,
	input wire nrst_i,
	input wire s_axi_awvalid_i,
	input wire s_axi_awready_o,
	input wire s_axi_wvalid_i,
	input wire s_axi_wready_o,
	input wire s_axi_bvalid_o,
	input wire s_axi_bready_i,
	input wire [1:0] s_axi_bresp_o,
	input wire s_axi_arvalid_i,
	input wire s_axi_arready_o,
	input wire s_axi_rvalid_o,
	input wire [31:0] s_axi_rdata_o,
	input wire pll_bus_wr_strobe_o,
	input wire converter_bias_on_o,
	input wire master_bias_on_o,
	input wire front_end_on_o,
	input wire converter_clock_on_o,
	input wire [15:0] chan_clock_on_o,
	input wire ref_receiver_on_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!nrst_i);
	sequence wr_taken;
		s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
	endsequence
	sequence wr_answer;
		!s_axi_bvalid_o ##1 s_axi_bvalid_o;
	endsequence
	AST_WR_ANSWER: assert property (wr_taken |=> wr_answer)
		else $error("write answer not on time");
	AST_B_HOLD: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
		else $error("write response dropped");
	AST_RD_ANSWER: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o && !s_axi_arready_o)
		else $error("read answer not on time");
	AST_RD_UPPER: assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h0)
		else $error("read upper bits not zero");
	AST_STROBE_PULSE: assert property (pll_bus_wr_strobe_o |=> !pll_bus_wr_strobe_o)
		else $error("strobe longer than one cycle");
	AST_MASTER_BIAS: assert property (master_bias_on_o |-> converter_bias_on_o)
		else $error("master bias on without bias bit");
	AST_FULL_GATE: assert property (converter_bias_on_o && !master_bias_on_o |->
		!front_end_on_o && !converter_clock_on_o && chan_clock_on_o == 16'h0)
		else $error("full shutdown left parts on");
	AST_RESET_VAL: assert property ($rose(nrst_i) |-> ref_receiver_on_o && chan_clock_on_o == 16'h0)
		else $error("wrong value after reset");
endmodule // pbr_regs_checker

bind pbr_regs pbr_regs_checker pbr_regs_checker_i (.*);

//--- dv/tb.sv
// self-checking bench for pbr_regs over axi4-lite
// assumes: pbr_consts.vh on the include path, checker bound separately
`timescale 1ns/10ps
`include "pbr_consts.vh"
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin err_count++; $display("BAD %0t got %h exp %h", $time, a, e); end end
module tb;
	logic core_clk_i, nrst_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i;
	logic shutdown_pin_i;
	logic [13:0] s_axi_awaddr_i, s_axi_araddr_i;
	logic [31:0] s_axi_wdata_i;
	logic [3:0] s_axi_wstrb_i;
	logic [7:0] pll_bus_rd_byte_i, pll_rev_i;
	wire s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
	wire [1:0] s_axi_bresp_o, s_axi_rresp_o;
	wire [31:0] s_axi_rdata_o;
	wire [7:0] pll_bus_addr_o, pll_bus_wr_byte_o, dither_current_one_o, dither_current_two_o;
	wire pll_bus_wr_strobe_o, pll_bus_rd_en_o, ref_low_power_o, ref_synca_sel_o, ref_receiver_on_o;
	wire [3:0] ref_cm_ctrl_o;
	wire calib_analog_on_o, calib_clock_on_o, extra_chan_on_o, converter_bias_on_o, master_bias_on_o;
	wire converter_clock_on_o, front_end_on_o;
	wire [15:0] chan_clock_on_o;
	wire [5:0] gain_trim_o, cap_trim_o;
	int err_count = 0;
	int num_checks = 0;
	int pulses = 0;
	int p;
	pbr_regs pbr_regs_i (.*);
	initial begin
		core_clk_i = 1'b0;
		forever #2 core_clk_i = ~core_clk_i;
	end
	// counts strobe cycles seen on the pll bus
	always @(posedge core_clk_i) if (pll_bus_wr_strobe_o) pulses <= pulses + 1;
	task end_of_test;
		if (err_count == 0 && num_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task settle;
		repeat (2) @(posedge core_clk_i);
		#1;
	endtask
	task wr(input [11:0] ix, input [7:0] d, input [1:0] er);
		@(posedge core_clk_i);
		s_axi_awaddr_i <= {ix, 2'b00};
		s_axi_wdata_i <= {24'h0, d};
		s_axi_awvalid_i <= 1'b1;
		s_axi_wvalid_i <= 1'b1;
		s_axi_bready_i <= 1'b1;
		do begin
			@(posedge core_clk_i);
			if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
			if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
		end while (!s_axi_bvalid_o);
		s_axi_bready_i <= 1'b0;
		`CHK(s_axi_bresp_o, er)
	endtask
	task rd(input [11:0] ix, input [7:0] ed, input [1:0] er);
		@(posedge core_clk_i);
		s_axi_araddr_i <= {ix, 2'b00};
		s_axi_arvalid_i <= 1'b1;
		s_axi_rready_i <= 1'b1;
		do begin
			@(posedge core_clk_i);
			if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
		end while (!s_axi_rvalid_o);
		s_axi_rready_i <= 1'b0;
		`CHK(s_axi_rdata_o, {24'h0, ed})
		`CHK(s_axi_rresp_o, er)
	endtask
	task t_reset;
		rd(`PBR_IDX_WR_DATA, 8'h00, 2'b00);
		rd(`PBR_IDX_RD_DATA, 8'h00, 2'b00);
		rd(`PBR_IDX_REF_CTRL, 8'h01, 2'b00);
		rd(`PBR_IDX_PLL_REV, 8'h5a, 2'b00);
		rd(`PBR_IDX_PWR_DOWN, 8'h00, 2'b00);
		rd(`PBR_IDX_CHAN_HIGH, 8'h00, 2'b00);
		`CHK(ref_receiver_on_o, 1'b1)
		`CHK(chan_clock_on_o, 16'h0)
	endtask
	task t_masks;
		wr(`PBR_IDX_REF_CTRL, 8'hff, 2'b00);
		rd(`PBR_IDX_REF_CTRL, 8'h7f, 2'b00);
		wr(`PBR_IDX_GAIN_TRIM, 8'hff, 2'b00);
		rd(`PBR_IDX_GAIN_TRIM, 8'h3f, 2'b00);
		wr(`PBR_IDX_CAP_TRIM, 8'hea, 2'b00);
		rd(`PBR_IDX_CAP_TRIM, 8'h2a, 2'b00);
		wr(`PBR_IDX_DITHER_ONE, 8'h96, 2'b00);
		wr(`PBR_IDX_DITHER_TWO, 8'h69, 2'b00);
		// lane 0 strobe low: the word must not be stored
		s_axi_wstrb_i <= 4'he;
		wr(`PBR_IDX_DITHER_ONE, 8'h11, 2'b00);
		s_axi_wstrb_i <= 4'hf;
		rd(`PBR_IDX_DITHER_ONE, 8'h96, 2'b00);
		wr(`PBR_IDX_RD_DATA, 8'hff, 2'b00);
		rd(`PBR_IDX_RD_DATA, 8'h00, 2'b00);
		wr(12'h525, 8'hff, 2'b10);
		rd(12'h525, 8'h00, 2'b10);
		wr(`PBR_IDX_CHAN_LOW, 8'h01, 2'b00);
		wr(`PBR_IDX_CHAN_HIGH, 8'h80, 2'b00);
		settle;
		`CHK({ref_cm_ctrl_o, ref_low_power_o, ref_synca_sel_o, ref_receiver_on_o}, 7'h7f)
		`CHK({gain_trim_o, cap_trim_o, dither_current_one_o, dither_current_two_o}, 28'hfea9669)
		`CHK(chan_clock_on_o, 16'h8001)
	endtask
	task t_pll;
		wr(`PBR_IDX_WR_DATA, 8'ha5, 2'b00);
		rd(`PBR_IDX_WR_DATA, 8'ha5, 2'b00);
		`CHK(pll_bus_wr_byte_o, 8'ha5)
		wr(`PBR_IDX_BUS_ADDR, 8'h4b, 2'b00);
		rd(`PBR_IDX_BUS_ADDR, 8'h4b, 2'b00);
		`CHK(pll_bus_addr_o, 8'h4b)
		p = pulses;
		wr(`PBR_IDX_WR_STROBE, 8'h01, 2'b00);
		settle;
		`CHK(pulses - p, 1)
		wr(`PBR_IDX_WR_STROBE, 8'h01, 2'b00);
		settle;
		`CHK(pulses - p, 1)
		wr(`PBR_IDX_WR_STROBE, 8'h00, 2'b00);
		wr(`PBR_IDX_WR_STROBE, 8'h01, 2'b00);
		settle;
		`CHK(pulses - p, 2)
		@(posedge core_clk_i);
		pll_bus_rd_byte_i <= 8'h3c;
		wr(`PBR_IDX_RD_EN, 8'h01, 2'b00);
		settle;
		`CHK(pll_bus_rd_en_o, 1'b1)
		rd(`PBR_IDX_RD_DATA, 8'h3c, 2'b00);
		wr(`PBR_IDX_RD_EN, 8'h00, 2'b00);
		pll_bus_rd_byte_i <= 8'h77;
		settle;
		rd(`PBR_IDX_RD_DATA, 8'h3c, 2'b00);
		`CHK(pll_bus_rd_en_o, 1'b0)
	endtask
	task t_power;
		wr(`PBR_IDX_PWR_DOWN, 8'he7, 2'b00);
		settle;
		`CHK({calib_analog_on_o, calib_clock_on_o, extra_chan_on_o, converter_bias_on_o, master_bias_on_o,
			converter_clock_on_o, front_end_on_o}, 7'h7f)
		for (int m = 0; m < 4; m++) begin
			wr(`PBR_IDX_PWR_DOWN, {3'b111, m[1:0], 3'b111}, 2'b00);
			shutdown_pin_i <= 1'b1;
			repeat (8) @(posedge core_clk_i);
			#1;
			`CHK({master_bias_on_o, front_end_on_o, converter_clock_on_o, chan_clock_on_o != 16'h0},
				{m != 3, m < 2, m == 0, m == 0})
			@(posedge core_clk_i);
			shutdown_pin_i <= 1'b0;
			repeat (8) @(posedge core_clk_i);
		end
		wr(`PBR_IDX_PWR_DOWN, 8'h00, 2'b00);
		settle;
		`CHK({calib_analog_on_o, calib_clock_on_o, extra_chan_on_o, converter_bias_on_o, converter_clock_on_o,
			front_end_on_o}, 6'h00)
	endtask
	// reset in mid-run must bring written registers back to their defaults
	task t_rereset;
		@(posedge core_clk_i);
		nrst_i <= 1'b0;
		repeat (2) @(posedge core_clk_i);
		nrst_i <= 1'b1;
		rd(`PBR_IDX_CHAN_LOW, 8'h00, 2'b00);
		rd(`PBR_IDX_GAIN_TRIM, 8'h00, 2'b00);
		`CHK(chan_clock_on_o, 16'h0)
		`CHK({ref_cm_ctrl_o, ref_low_power_o, ref_synca_sel_o, ref_receiver_on_o}, 7'h01)
	endtask
	initial begin
		{nrst_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i} = 6'h0;
		{s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i, pll_bus_rd_byte_i, shutdown_pin_i} = 69'h0;
		s_axi_wstrb_i = 4'hf;
		pll_rev_i = 8'h5a;
		repeat (2) @(posedge core_clk_i);
		nrst_i <= 1'b1;
		t_reset;
		t_masks;
		t_pll;
		t_power;
		t_rereset;
		end_of_test;
	end
	initial begin
		#20000;
		err_count++;
		end_of_test;
	end
endmodule // tb
